// File: pdt_cfg.svh
`ifndef PDT_CFG_SVH
`define PDT_CFG_SVH
// register byte offsets
`define PDT_OFF_PHASE 8'h00
`define PDT_OFF_SPHASE 8'h04
`define PDT_OFF_DT 8'h08
`define PDT_OFF_ALTDT 8'h0c
`define PDT_OFF_TRG 8'h10
`define PDT_OFF_PIN 8'h14
`define PDT_OFF_GEN 8'h18
`define PDT_OFF_STAT 8'h1c
// reset values
`define PDT_PIN_RST 16'hc000
`define PDT_ZERO16 16'h0000
// field positions
`define PDT_DT_MSB 13
`define PDT_TRG_DIV_LSB 12
`define PDT_TRG_DTM_BIT 7
`define PDT_TRG_STRT_LSB 0
`define PDT_GEN_EN_BIT 0
`define PDT_GEN_ITB_BIT 9
`define PDT_GEN_TRGIEN_BIT 10
`define PDT_GEN_IFLT_BIT 15
// local period limits
`define PDT_PER_MAX 16'hfff8
`define PDT_SPER_MIN 16'h0010
`endif

// File: pdt_pkg.sv
package pdt_pkg;
  typedef enum logic [1:0] {
    PDT_COMPL = 2'h0,
    PDT_REDUN = 2'h1,
    PDT_PUSHPULL = 2'h2,
    PDT_INDEP = 2'h3
  } pdt_mode_e;
  typedef struct packed {
    logic high_pin_own;
    logic low_pin_own;
    logic high_pin_invert;
    logic low_pin_invert;
    pdt_mode_e pair_output_mode;
    logic high_override_en;
    logic low_override_en;
    logic [1:0] override_value;
    logic [1:0] fault_state_value;
    logic [1:0] limit_state_value;
    logic swap;
    logic override_sync;
  } pdt_pin_s;
  typedef struct packed {
    logic [15:0] high_value;
    logic [15:0] low_value;
    logic high_is_period;
    logic low_is_period;
  } pdt_timing_s;
  typedef enum logic [2:0] {
    PDT_IDLE = 3'b001,
    PDT_DELAY = 3'b010,
    PDT_RUN = 3'b100
  } pdt_trg_e;
endpackage : pdt_pkg

// File: pdt_slice.sv
// Contract
// - non-independent master base: primary phase both outputs
// - independent master base: primary high, secondary low
// - local base: primary phase is period, max fff8; not clamped here, any 16-bit value passes
// - secondary phase ignored in non-independent modes
// - independent local: secondary is low period
// - dead time 14 bits, upper bits read zero
// - alternate dead time 14 bits, upper zero
// - trigger divider emits every N+1 events
// - dual trigger merge combines secondary with primary
// - wait start-field PWM cycles before first trigger
// - secondary triggers never raise trigger interrupt
// - ownership bits select PWM or GPIO; reset one
// - polarity bit one makes pin active-low
// - pair mode selects compl, redundant, push-pull, indep; only indep is decoded here, for the low timing value
// - override enables put override data on pins
// - fault forces fault data; split mode current-limit high
// - override sync waits for time base boundary
// - swap exchanges high and low pin signals
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "pdt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pdt_slice (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // generator side (same clock)
  input wire logic gen_high_in,
  input wire logic gen_low_in,
  input wire logic pwm_cycle_end,
  input wire logic pri_trig_event,
  input wire logic sec_trig_event,
  // fault inputs from pins
  input wire logic fault_in,
  input wire logic limit_in,
  // gpio fallback
  input wire logic gpio_high_in,
  input wire logic gpio_low_in,
  // outputs
  output logic high_output,
  output logic low_output,
  output var pdt_pkg::pdt_timing_s timing,
  output logic [13:0] dead_time_count,
  output logic [13:0] alt_dead_time_count,
  output logic pri_trig_out,
  output logic sec_trig_out,
  output logic trig_irq
);
  import pdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] primary_phase_value_r;
  logic [15:0] secondary_phase_value_r;
  logic [13:0] dt_r;
  logic [13:0] alt_dt_r;
  logic [3:0] trigger_divider_r;
  logic dual_trigger_merge_r;
  logic [5:0] trigger_start_delay_r;
  pdt_pin_s pin_ctrl_reg_r;
  logic gen_en_r;
  logic local_time_base_sel_r;
  logic trg_ien_r;
  logic split_fault_mode_r;
  logic trg_stat_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic [31:0] rd_nxt;
  logic rd_hit;
  logic wr_hit;
  logic wr_fire;
  logic [15:0] dt_wr;
  logic [15:0] adt_wr;
  logic [15:0] trg_wr;
  logic [15:0] gen_wr;

  ////////////////////////////////////////////////////////////////////////
  // bus write path: address and data in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign s_axi_bresp = wr_hit ? 2'h0 : 2'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  logic wr_hit_r;
  assign wr_hit = wr_hit_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      wr_hit_r <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      wr_hit_r <= (awaddr_r[1:0] == 2'h0) && (awaddr_r <= `PDT_OFF_STAT);
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte lanes 0 and 1 merge into the old value
  function automatic logic [15:0] merge16(input logic [15:0] old);
    merge16 = old;
    if (wstrb_r[0]) merge16[7:0] = wdata_r[7:0];
    if (wstrb_r[1]) merge16[15:8] = wdata_r[15:8];
  endfunction : merge16

  function automatic logic [15:0] pin_word(input pdt_pin_s p);
    pin_word = {p.high_pin_own, p.low_pin_own, p.high_pin_invert, p.low_pin_invert,
                p.pair_output_mode, p.high_override_en, p.low_override_en,
                p.override_value, p.fault_state_value, p.limit_state_value,
                p.swap, p.override_sync};
  endfunction : pin_word

  logic [15:0] gen_word;
  assign gen_word = {split_fault_mode_r, 4'h0, trg_ien_r, local_time_base_sel_r, 8'h00, gen_en_r};

  ////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_phase_value_r <= `PDT_ZERO16;
      secondary_phase_value_r <= `PDT_ZERO16;
    end else if (wr_fire && awaddr_r == `PDT_OFF_PHASE) begin
      primary_phase_value_r <= merge16(primary_phase_value_r);
    end else if (wr_fire && awaddr_r == `PDT_OFF_SPHASE) begin
      secondary_phase_value_r <= merge16(secondary_phase_value_r);
    end
  end

  // merged write words, one per register that keeps only some bits
  assign dt_wr = merge16({2'h0, dt_r});
  assign adt_wr = merge16({2'h0, alt_dt_r});
  assign trg_wr = merge16({trigger_divider_r, 4'h0, dual_trigger_merge_r, 1'b0,
                           trigger_start_delay_r});
  assign gen_wr = merge16(gen_word);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dt_r <= 14'h0000;
      alt_dt_r <= 14'h0000;
    end else if (wr_fire && awaddr_r == `PDT_OFF_DT) begin
      dt_r <= dt_wr[`PDT_DT_MSB:0];
    end else if (wr_fire && awaddr_r == `PDT_OFF_ALTDT) begin
      alt_dt_r <= adt_wr[`PDT_DT_MSB:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger_divider_r <= 4'h0;
      dual_trigger_merge_r <= 1'b0;
      trigger_start_delay_r <= 6'h00;
    end else if (wr_fire && awaddr_r == `PDT_OFF_TRG) begin
      trigger_divider_r <= trg_wr[`PDT_TRG_DIV_LSB +: 4];
      dual_trigger_merge_r <= trg_wr[`PDT_TRG_DTM_BIT];
      trigger_start_delay_r <= trg_wr[`PDT_TRG_STRT_LSB +: 6];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ctrl_reg_r <= pdt_pin_s'(`PDT_PIN_RST);
    end else if (wr_fire && awaddr_r == `PDT_OFF_PIN) begin
      pin_ctrl_reg_r <= pdt_pin_s'(merge16(pin_word(pin_ctrl_reg_r)));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_en_r <= 1'b0;
      local_time_base_sel_r <= 1'b0;
      trg_ien_r <= 1'b0;
      split_fault_mode_r <= 1'b0;
    end else if (wr_fire && awaddr_r == `PDT_OFF_GEN) begin
      gen_en_r <= gen_wr[`PDT_GEN_EN_BIT];
      local_time_base_sel_r <= gen_wr[`PDT_GEN_ITB_BIT];
      trg_ien_r <= gen_wr[`PDT_GEN_TRGIEN_BIT];
      split_fault_mode_r <= gen_wr[`PDT_GEN_IFLT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PDT_OFF_PHASE: rd_nxt[15:0] = primary_phase_value_r;
      `PDT_OFF_SPHASE: rd_nxt[15:0] = secondary_phase_value_r;
      `PDT_OFF_DT: rd_nxt[15:0] = {2'h0, dt_r};
      `PDT_OFF_ALTDT: rd_nxt[15:0] = {2'h0, alt_dt_r};
      `PDT_OFF_TRG: rd_nxt[15:0] = {trigger_divider_r, 4'h0, dual_trigger_merge_r, 1'b0,
                                    trigger_start_delay_r};
      `PDT_OFF_PIN: rd_nxt[15:0] = pin_word(pin_ctrl_reg_r);
      `PDT_OFF_GEN: rd_nxt[15:0] = gen_word;
      `PDT_OFF_STAT: rd_nxt[15:0] = {15'h0000, trg_stat_r};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase or period selection
  logic indep;
  assign indep = (pin_ctrl_reg_r.pair_output_mode == PDT_INDEP);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing <= '0;
      dead_time_count <= 14'h0000;
      alt_dead_time_count <= 14'h0000;
    end else begin
      timing.high_value <= primary_phase_value_r;
      timing.high_is_period <= local_time_base_sel_r;
      timing.low_value <= indep ? secondary_phase_value_r : primary_phase_value_r;
      timing.low_is_period <= local_time_base_sel_r;
      dead_time_count <= dt_r;
      alt_dead_time_count <= alt_dt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger start delay, postscaler and merge
  pdt_trg_e trg_st_r;
  logic [5:0] start_cnt_r;
  logic [3:0] div_cnt_r;
  logic pri_ev;
  logic sec_sep;
  assign pri_ev = pri_trig_event || (dual_trigger_merge_r && sec_trig_event);
  assign sec_sep = !dual_trigger_merge_r && sec_trig_event;

  always_ff @(posedge aclk) begin
    if (!aresetn || !gen_en_r) begin
      trg_st_r <= PDT_IDLE;
      start_cnt_r <= 6'h00;
    end else begin
      case (trg_st_r)
        PDT_IDLE: begin
          start_cnt_r <= trigger_start_delay_r;
          trg_st_r <= (trigger_start_delay_r == 6'h00) ? PDT_RUN : PDT_DELAY;
        end
        PDT_DELAY: begin
          if (pwm_cycle_end) begin
            start_cnt_r <= start_cnt_r - 6'h01;
            if (start_cnt_r == 6'h01) trg_st_r <= PDT_RUN;
          end
        end
        PDT_RUN: trg_st_r <= PDT_RUN;
        default: trg_st_r <= PDT_IDLE;
      endcase
    end
  end

  logic fire_pri;
  assign fire_pri = (trg_st_r == PDT_RUN) && pri_ev && (div_cnt_r == trigger_divider_r);
  always_ff @(posedge aclk) begin
    if (!aresetn || !gen_en_r) begin
      div_cnt_r <= 4'h0;
    end else if (trg_st_r == PDT_RUN && pri_ev) begin
      div_cnt_r <= (div_cnt_r == trigger_divider_r) ? 4'h0 : div_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_trig_out <= 1'b0;
      sec_trig_out <= 1'b0;
    end else begin
      pri_trig_out <= fire_pri;
      sec_trig_out <= (trg_st_r == PDT_RUN) && sec_sep;
    end
  end

  // status cleared by dropping the enable; the clear wins over a set
  always_ff @(posedge aclk) begin
    if (!aresetn || !trg_ien_r) begin
      trg_stat_r <= 1'b0;
    end else if (fire_pri && pri_trig_event) begin
      trg_stat_r <= 1'b1;
    end
  end
  assign trig_irq = trg_stat_r;

  ////////////////////////////////////////////////////////////////////////
  // pin path: fault and limit synchronisers
  logic [1:0] flt_sync_r;
  logic [1:0] lim_sync_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_sync_r <= 2'h0;
      lim_sync_r <= 2'h0;
    end else begin
      flt_sync_r <= {flt_sync_r[0], fault_in};
      lim_sync_r <= {lim_sync_r[0], limit_in};
    end
  end

  // override enables and data, optionally held to cycle boundary
  logic [3:0] ovr_act_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_act_r <= 4'h0;
    end else if (!pin_ctrl_reg_r.override_sync || pwm_cycle_end) begin
      ovr_act_r <= {pin_ctrl_reg_r.high_override_en, pin_ctrl_reg_r.low_override_en,
                    pin_ctrl_reg_r.override_value};
    end
  end

  logic h_sig;
  logic l_sig;
  always_comb begin
    h_sig = pin_ctrl_reg_r.swap ? gen_low_in : gen_high_in;
    l_sig = pin_ctrl_reg_r.swap ? gen_high_in : gen_low_in;
    if (ovr_act_r[3]) h_sig = ovr_act_r[1];
    if (ovr_act_r[2]) l_sig = ovr_act_r[0];
    if (split_fault_mode_r) begin
      if (lim_sync_r[1]) h_sig = pin_ctrl_reg_r.fault_state_value[1];
      if (flt_sync_r[1]) l_sig = pin_ctrl_reg_r.fault_state_value[0];
    end else if (flt_sync_r[1]) begin
      h_sig = pin_ctrl_reg_r.fault_state_value[1];
      l_sig = pin_ctrl_reg_r.fault_state_value[0];
    end else if (lim_sync_r[1]) begin
      h_sig = pin_ctrl_reg_r.limit_state_value[1];
      l_sig = pin_ctrl_reg_r.limit_state_value[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_output <= 1'b0;
      low_output <= 1'b0;
    end else begin
      high_output <= pin_ctrl_reg_r.high_pin_own ?
                     (h_sig ^ pin_ctrl_reg_r.high_pin_invert) : gpio_high_in;
      low_output <= pin_ctrl_reg_r.low_pin_own ?
                    (l_sig ^ pin_ctrl_reg_r.low_pin_invert) : gpio_low_in;
    end
  end
endmodule : pdt_slice
`default_nettype wire

// File: pdt_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_stage_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // gate drive and conversion starts
  input wire logic high_output,
  input wire logic low_output,
  input wire logic pri_trig_out,
  input wire logic sec_trig_out,
  // conversion start tallies
  output logic [7:0] n_pri,
  output logic [7:0] n_sec
);
  // adc side counts every start pulse it sees
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_pri <= 8'h00;
      n_sec <= 8'h00;
    end else begin
      n_pri <= n_pri + {7'h00, pri_trig_out};
      n_sec <= n_sec + {7'h00, sec_trig_out};
    end
  end
endmodule : pdt_stage_model
`default_nettype wire

// File: pdt_slice_props.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_slice_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // triggers
  input wire logic pri_trig_event,
  input wire logic sec_trig_event,
  input wire logic pri_trig_out,
  input wire logic sec_trig_out,
  input wire logic trig_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  a_aw_stalls: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_ar_stalls: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_pri_cause: assert property (pri_trig_out |-> $past(pri_trig_event) || $past(sec_trig_event))
    else $error("primary trigger without event");
  a_sec_cause: assert property (sec_trig_out |-> $past(sec_trig_event))
    else $error("secondary trigger without event");
  a_irq_cause: assert property ($rose(trig_irq) |-> pri_trig_out || $past(pri_trig_out))
    else $error("trigger status without primary trigger");
  ////////////////////////////////////////////////////////////////
  c_pri: cover property (pri_trig_out);
  c_sec: cover property (sec_trig_out);
  c_irq: cover property ($rose(trig_irq));
endmodule : pdt_slice_props
bind pdt_slice pdt_slice_props props_u (.*);
`default_nettype wire

// File: pdt_slice_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdt_cfg.svh"
module pdt_slice_test;
  import pdt_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic gen_high_in = 1'h1, gen_low_in = 1'h0, gpio_high_in = 1'h1, gpio_low_in = 1'h1;
  logic pwm_cycle_end = 1'h0, pri_trig_event = 1'h0, sec_trig_event = 1'h0;
  logic fault_in = 1'h0, limit_in = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lresp;
  logic high_output, low_output, pri_trig_out, sec_trig_out, trig_irq;
  pdt_timing_s timing;
  logic [13:0] dead_time_count, alt_dead_time_count;
  logic [7:0] n_pri, n_sec, c0, c1;
  logic [3:0] dv [3] = '{4'h0, 4'h2, 4'hf};
  int n_errors = 0;
  int comparisons = 0;
  always #5 aclk = ~aclk;
  pdt_slice dut_u (.*);
  pdt_stage_model stage_u (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // sample handshakes at the rising edge itself
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      b = s_axi_bvalid;
      lresp = s_axi_bresp;
    end
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic r;
    r = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      r = s_axi_rvalid;
      v = s_axi_rdata;
      lresp = s_axi_rresp;
    end
    s_axi_rready <= 1'h0;
  endtask : rd
  // let registered outputs land, look mid-cycle
  task automatic st;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : st
  // one-cycle pulse of {cycle end, secondary, primary}
  task automatic ev(input logic [2:0] m);
    @(posedge aclk);
    {pwm_cycle_end, sec_trig_event, pri_trig_event} <= m;
    @(posedge aclk);
    {pwm_cycle_end, sec_trig_event, pri_trig_event} <= 3'h0;
  endtask : ev
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`PDT_OFF_PIN, d);
    chk("pin_rst", d, 32'h0000c000);
    st;
    chk("pins", {high_output, low_output}, 2'h2);
    wr(`PDT_OFF_PIN, 32'h0000);
    st;
    chk("pins", {high_output, low_output}, 2'h3);
    wr(`PDT_OFF_PIN, 32'hf000);
    st;
    chk("pins", {high_output, low_output}, 2'h1);
    wr(`PDT_OFF_PIN, 32'hc002);
    st;
    chk("pins", {high_output, low_output}, 2'h1);
    wr(`PDT_OFF_PIN, 32'hc341);
    st;
    chk("pins", {high_output, low_output}, 2'h2);
    ev(3'h4);
    st;
    chk("pins", {high_output, low_output}, 2'h1);
    wr(`PDT_OFF_PIN, 32'hc300);
    st;
    chk("pins", {high_output, low_output}, 2'h0);
    wr(`PDT_OFF_PIN, 32'hc010);
    wr(`PDT_OFF_GEN, 32'h8000);
    @(posedge aclk);
    limit_in <= 1'h1;
    st;
    chk("pins", {high_output, low_output}, 2'h0);
    @(posedge aclk);
    limit_in <= 1'h0;
    wr(`PDT_OFF_GEN, 32'h0);
    @(posedge aclk);
    fault_in <= 1'h1;
    st;
    chk("pins", {high_output, low_output}, 2'h1);
    @(posedge aclk);
    fault_in <= 1'h0;
    wr(`PDT_OFF_PHASE, 32'h1234);
    wr(`PDT_OFF_SPHASE, 32'h0567);
    for (int i = 0; i < 8; i++) begin
      wr(`PDT_OFF_PIN, {20'h0, 2'h3, i[1:0], 10'h0});
      wr(`PDT_OFF_GEN, {22'h0, i[2], 9'h0});
      st;
      chk("tval", {timing.high_value, timing.low_value},
          {16'h1234, (i[1:0] == 2'h3) ? 16'h0567 : 16'h1234});
      chk("tper", {timing.high_is_period, timing.low_is_period}, {2{i[2]}});
    end
    wr(`PDT_OFF_DT, 32'hffff);
    rd(`PDT_OFF_DT, d);
    chk("dt", d, 32'h3fff);
    chk("dtc", dead_time_count, 14'h3fff);
    wr(`PDT_OFF_ALTDT, 32'hc00a);
    rd(`PDT_OFF_ALTDT, d);
    chk("adt", d, 32'h000a);
    chk("adtc", alt_dead_time_count, 14'h000a);
    foreach (dv[k]) begin
      wr(`PDT_OFF_TRG, {16'h0, dv[k], 12'h0});
      wr(`PDT_OFF_GEN, 32'h1);
      c0 = n_pri;
      repeat (2 * (dv[k] + 1)) ev(3'h1);
      st;
      chk("div", n_pri - c0, 32'h2);
      wr(`PDT_OFF_GEN, 32'h0);
    end
    wr(`PDT_OFF_TRG, 32'h1080);
    wr(`PDT_OFF_GEN, 32'h1);
    c0 = n_pri;
    ev(3'h1);
    ev(3'h2);
    st;
    chk("merge", n_pri - c0, 32'h1);
    wr(`PDT_OFF_GEN, 32'h0);
    wr(`PDT_OFF_TRG, 32'h1000);
    wr(`PDT_OFF_GEN, 32'h1);
    c0 = n_pri;
    c1 = n_sec;
    ev(3'h1);
    ev(3'h2);
    st;
    chk("sep_p", n_pri - c0, 32'h0);
    chk("sep_s", n_sec - c1, 32'h1);
    wr(`PDT_OFF_GEN, 32'h0);
    wr(`PDT_OFF_TRG, 32'h0003);
    wr(`PDT_OFF_GEN, 32'h1);
    c0 = n_pri;
    ev(3'h1);
    ev(3'h4);
    ev(3'h4);
    ev(3'h1);
    st;
    chk("strt", n_pri - c0, 32'h0);
    ev(3'h4);
    st;
    ev(3'h1);
    st;
    chk("strt", n_pri - c0, 32'h1);
    wr(`PDT_OFF_GEN, 32'h0);
    wr(`PDT_OFF_TRG, 32'h0);
    wr(`PDT_OFF_GEN, 32'h401);
    ev(3'h2);
    st;
    chk("irq", trig_irq, 32'h0);
    ev(3'h1);
    st;
    chk("irq", trig_irq, 32'h1);
    rd(`PDT_OFF_STAT, d);
    chk("stat", d, 32'h1);
    wr(`PDT_OFF_GEN, 32'h0);
    st;
    chk("irq", trig_irq, 32'h0);
    rd(8'h20, d);
    chk("rresp", lresp, 32'h2);
    chk("rdata", d, 32'h0);
    wr(8'h20, 32'h5);
    chk("bresp", lresp, 32'h2);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict;
  end
endmodule : pdt_slice_test
`default_nettype wire
